// ---- rtl/safety_output_ctrl.sv ----
// Top: safety switch outputs, restart interlock, contactor feedback check,
// scan filter, external test input and muting bridge.
// Assumes all pin inputs are asynchronous to CLK; one scan_done pulse per scan.
//
// Functional notes
// RULE1: Outputs stay off until manual restart.
// RULE2: Compare contactor feedback against output state continuously.
// RULE3: Feedback open while on, 0 V while off.
// RULE4: Allow feedback 500 ms before declaring fault.
// RULE5: Signal output low while on, high off.
// RULE6: Switch off only after consecutive interrupted scans.
// RULE7: External test pulse at most 150 ms.
// RULE8: Muting keeps outputs on despite beam interruption.
// RULE9: Muting starts automatically from both sensors.
// RULE10: Muting indicator on exactly while muting.
// RULE11: Muting ends when timeout exceeded.
// RULE12: Standard muting timeout is 10 minutes.
// RULE13: Restart button resets faults and muting errors.
// RULE14: Second sensor within 4 s of first.
// RULE15: Ignore single sensor dropout up to 3 s.
// RULE16: Short filter variant uses 0.1 s/50 ms.
// RULE17: Both sensors inactive ends muting.
// RULE18: Feedback fault forces off until restart.
// RULE19: Interrupted scan count is a parameter.
`default_nettype none
module safety_output_ctrl #(
   parameter int unsigned SCAN_COUNT  = safety_pkg::SCAN_FILTER_DEF,
   parameter bit          SHORT_FILT  = 1'b0,
   parameter int unsigned TIMEOUT_TKS = safety_pkg::MUTE_TIMEOUT_TKS,
   parameter int unsigned TICK_CYC    = safety_pkg::MS_TICK_CYCLES
) (
   input  wire logic CLK,
   input  wire logic NRST,
   input  wire logic BEAM_CLEAR,
   input  wire logic SCAN_DONE,
   input  wire logic RESTART_INTERLOCK_BTN,
   input  wire logic CONTACTOR_FEEDBACK_MONITOR,
   input  wire logic FIRST_MUTING_SENSOR,
   input  wire logic SECOND_MUTING_SENSOR,
   input  wire logic TEST_IN,
   output logic      SAFETY_SWITCH_OUTPUT,
   output logic      SIGNAL_OUT,
   output logic      MUTING_INDICATOR,
   output logic      RESTART_LOCKED,
   output logic      FEEDBACK_FAULT,
   output logic      TEST_FAULT
);
   // The counters below are 8, 24 and 32 bits wide; refuse values they cannot hold
   if (SCAN_COUNT < 1 || SCAN_COUNT > 255) begin : g_bad_scan
      $error("safety_output_ctrl: SCAN_COUNT out of range");
   end
   if (TICK_CYC < 1) begin : g_bad_tick
      $error("safety_output_ctrl: TICK_CYC out of range");
   end
   if (TIMEOUT_TKS < 1) begin : g_bad_timeout
      $error("safety_output_ctrl: TIMEOUT_TKS out of range");
   end

   // Counts 1 ms ticks while run is high and restarts from zero when it drops
   function automatic logic [23:0] run_count(input logic [23:0] c, input logic run,
                                             input logic tk);
      if (!run)
         run_count = 24'h000000;
      else if (tk)
         run_count = safety_pkg::sat_inc(c);
      else
         run_count = c;
   endfunction

   // Two-flop synchronisers for every pin input
   logic [6:0] s1_reg, s1_next;
   logic [6:0] s2_reg, s2_next;
   always_comb begin
      s1_next = {BEAM_CLEAR, SCAN_DONE, RESTART_INTERLOCK_BTN,
                 CONTACTOR_FEEDBACK_MONITOR, FIRST_MUTING_SENSOR,
                 SECOND_MUTING_SENSOR, TEST_IN};
      s2_next = s1_reg;
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s1_reg <= 7'h00;
         s2_reg <= 7'h00;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end
   logic beam_ok, scan_s, btn_s, fb_s, ms1_s, ms2_s, test_s;
   assign {beam_ok, scan_s, btn_s, fb_s, ms1_s, ms2_s, test_s} = s2_reg;

   // Edge detect on synchronised scan strobe and button
   logic scan_d_reg, scan_d_next;
   logic btn_d_reg,  btn_d_next;
   logic scan_p,     btn_p;
   assign scan_p = scan_s & ~scan_d_reg;
   assign btn_p  = ~btn_s & btn_d_reg; // Release acts, so a stuck button cannot restart
   always_comb begin
      scan_d_next = scan_s;
      btn_d_next  = btn_s;
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         scan_d_reg <= 1'b0;
         btn_d_reg  <= 1'b0;
      end else begin
         scan_d_reg <= scan_d_next;
         btn_d_reg  <= btn_d_next;
      end
   end

   // 1 ms tick divider
   logic [31:0] div_reg, div_next;
   logic        tick;
   assign tick = (div_reg == TICK_CYC - 1);
   always_comb begin
      div_next = tick ? 32'h00000000 : div_reg + 32'h00000001;
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         div_reg <= 32'h00000000;
      end else begin
         div_reg <= div_next;
      end
   end

   // Scan filter; starts tripped so a clear scan is needed before any restart outside muting
   logic [7:0] bad_reg, bad_next;
   logic       beam_trip_reg, beam_trip_next;
   always_comb begin
      bad_next = bad_reg;
      beam_trip_next = beam_trip_reg;
      if (scan_p) begin
         if (beam_ok) begin
            bad_next = 8'h00;
            beam_trip_next = 1'b0;
         end else if (bad_reg >= 8'(SCAN_COUNT - 1)) begin
            beam_trip_next = 1'b1; // RULE6 RULE19
         end else begin
            bad_next = bad_reg + 8'h01; // RULE6
         end
      end
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         bad_reg       <= 8'h00;
         beam_trip_reg <= 1'b1;
      end else begin
         bad_reg       <= bad_next;
         beam_trip_reg <= beam_trip_next;
      end
   end

   // Muting sequencer
   mute_if mif ();
   muting_seq #(
      .DROP_ONE_MS (SHORT_FILT ? safety_pkg::DROPOUT_ONE_MS : safety_pkg::DROPOUT_MS),
      .DROP_TWO_MS (safety_pkg::DROPOUT_TWO_MS),
      .TIMEOUT_TKS (TIMEOUT_TKS)
   ) u_mute (
      .clk      (CLK),
      .nrst     (NRST),
      .tick     (tick),
      .first_s  (ms1_s),
      .second_s (ms2_s),
      .mif      (mif.seq)
   );

   // Output state, interlock, feedback and test supervision
   logic        on_reg, on_next;
   logic        lock_reg, lock_next;
   logic        fbf_reg, fbf_next;
   logic        tf_reg, tf_next;
   logic [23:0] fbc_reg, fbc_next;
   logic [23:0] tc_reg, tc_next;
   logic        sig_reg, sig_next;
   logic        fb_match, trip;
   logic        fb_clr, tf_clr, mute_clr;

   // Feedback open (high) while on, pulled to 0 V while off
   assign fb_match = (fb_s == on_reg); // RULE2 RULE3
   // A release that clears the last fault also restarts, so one press does both
   assign fb_clr   = btn_p & fb_match; // RULE18 RULE13
   assign tf_clr   = btn_p & ~test_s; // RULE13
   assign mute_clr = mif.override & ~ms1_s & ~ms2_s; // RULE13
   assign trip = (beam_trip_reg & ~mif.active) | (fbf_reg & ~fb_clr) | (tf_reg & ~tf_clr)
               | test_s | (mif.fault & ~mute_clr); // RULE8
   assign mif.override = btn_p & lock_reg; // RULE13

   // Contactor feedback supervision
   always_comb begin
      fbc_next = run_count(fbc_reg, ~fb_match, tick); // RULE4
      fbf_next = fbf_reg;
      if (fb_clr) begin
         fbf_next = 1'b0; // RULE18 RULE13
      end
      // A new mismatch wins over a clear in the same cycle
      if (!fb_match && fbc_reg >= 24'(safety_pkg::FEEDBACK_WINDOW_TKS)) begin
         fbf_next = 1'b1; // RULE2 RULE4
      end
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         fbc_reg <= 24'h000000;
         fbf_reg <= 1'b0;
      end else begin
         fbc_reg <= fbc_next;
         fbf_reg <= fbf_next;
      end
   end

   // External test supervision
   always_comb begin
      tc_next = run_count(tc_reg, test_s, tick);
      tf_next = tf_reg;
      if (tf_clr) begin
         tf_next = 1'b0; // RULE13
      end
      // Over-long test pulse treated as a wiring fault
      if (test_s && tc_reg >= 24'(safety_pkg::TEST_MAX_TKS)) begin
         tf_next = 1'b1; // RULE7
      end
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tc_reg <= 24'h000000;
         tf_reg <= 1'b0;
      end else begin
         tc_reg <= tc_next;
         tf_reg <= tf_next;
      end
   end

   // Switch output and restart interlock
   always_comb begin
      on_next   = on_reg;
      lock_next = lock_reg;
      if (trip) begin
         on_next   = 1'b0; // RULE18
         lock_next = 1'b1; // RULE1
      end else if (lock_reg && btn_p) begin
         lock_next = 1'b0; // RULE1
         on_next   = 1'b1;
      end
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         on_reg   <= safety_pkg::OUT_OFF_RESET;
         lock_reg <= 1'b1;
      end else begin
         on_reg   <= on_next;
         lock_reg <= lock_next;
      end
   end

   // Signal output from its own flop, updated on the same edge as the switch output
   always_comb begin
      sig_next = ~on_next; // RULE5
   end
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sig_reg <= ~safety_pkg::OUT_OFF_RESET;
      end else begin
         sig_reg <= sig_next;
      end
   end

   assign SAFETY_SWITCH_OUTPUT = on_reg;
   assign SIGNAL_OUT           = sig_reg; // RULE5
   assign MUTING_INDICATOR     = mif.active; // RULE10
   assign RESTART_LOCKED       = lock_reg;
   assign FEEDBACK_FAULT       = fbf_reg;
   assign TEST_FAULT           = tf_reg;
endmodule
`default_nettype wire

// ---- rtl/safety_pkg.sv ----
// Package: constants shared by the safety output and muting control logic.
// Assumes a 50 MHz system clock; times are converted to 1 ms tick counts here, and the tick to cycles.
`default_nettype none
package safety_pkg;
   localparam int unsigned CLK_HZ              = 50_000_000;
   localparam int unsigned FEEDBACK_WINDOW_MS  = 500;
   localparam int unsigned MUTE_TIMEOUT_MIN    = 10;
   localparam int unsigned SIMUL_WINDOW_S      = 4;
   localparam int unsigned DROPOUT_MS          = 3000;
   localparam int unsigned DROPOUT_ONE_MS      = 100;
   localparam int unsigned DROPOUT_TWO_MS      = 50;
   localparam int unsigned DROPOUT_FOUR_MS     = 300;
   localparam int unsigned TEST_MAX_MS         = 150;
   localparam int unsigned MS_TICK_CYCLES      = CLK_HZ / 1000;
   localparam int unsigned FEEDBACK_WINDOW_TKS = FEEDBACK_WINDOW_MS;
   localparam int unsigned MUTE_TIMEOUT_TKS    = MUTE_TIMEOUT_MIN * 60 * 1000;
   localparam int unsigned SIMUL_WINDOW_TKS    = SIMUL_WINDOW_S * 1000;
   localparam int unsigned TEST_MAX_TKS        = TEST_MAX_MS;
   localparam int unsigned SCAN_FILTER_DEF     = 3;
   localparam logic        OUT_OFF_RESET       = 1'b0;

   typedef enum logic [2:0] {
      MUTE_IDLE   = 3'b000,
      MUTE_FIRST  = 3'b001,
      MUTE_ACTIVE = 3'b010,
      MUTE_FAULT  = 3'b011
   } mute_state_e;

   function automatic logic [23:0] sat_inc(input logic [23:0] v);
      sat_inc = (v == 24'hFFFFFF) ? v : v + 24'h000001;
   endfunction
endpackage
`default_nettype wire

// ---- rtl/mute_if.sv ----
// Interface: muting status between the muting sequencer and the output control.
// Assumes both sides share CLK.
`default_nettype none
interface mute_if;
   logic active;
   logic fault;
   logic override;
   modport seq  (output active, output fault, input  override);
   modport ctrl (input  active, input  fault, output override);
endinterface
`default_nettype wire

// ---- rtl/muting_seq.sv ----
// Timing-controlled two-sensor muting sequencer with dropout filter and timeout.
// Assumes sensor inputs already synchronised and a one-cycle 1 ms tick.
`default_nettype none
module muting_seq #(
   parameter int unsigned DROP_ONE_MS = safety_pkg::DROPOUT_MS,
   parameter int unsigned DROP_TWO_MS = safety_pkg::DROPOUT_TWO_MS,
   parameter int unsigned TIMEOUT_TKS = safety_pkg::MUTE_TIMEOUT_TKS
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic tick,
   input  wire logic first_s,
   input  wire logic second_s,
   mute_if.seq       mif
);
   // Counters are 24 bits wide; refuse limits that they cannot reach
   if (TIMEOUT_TKS >= 24'hFFFFFF || DROP_ONE_MS == 0 || DROP_TWO_MS == 0) begin : g_bad_param
      $error("muting_seq: parameter out of range");
   end

   safety_pkg::mute_state_e state_reg, state_next;
   logic [23:0] win_reg, win_next;
   logic [23:0] dur_reg, dur_next;
   logic [23:0] drop_reg, drop_next;
   logic        both, none, one;

   assign both = first_s & second_s;
   assign none = ~first_s & ~second_s;
   assign one  = first_s ^ second_s;

   always_comb begin
      state_next = state_reg;
      win_next   = win_reg;
      dur_next   = dur_reg;
      drop_next  = drop_reg;
      case (state_reg)
         safety_pkg::MUTE_IDLE: begin
            win_next = '0;
            dur_next = '0;
            drop_next = '0;
            if (both)
               state_next = safety_pkg::MUTE_ACTIVE; // RULE9
            else if (one)
               state_next = safety_pkg::MUTE_FIRST;
         end
         safety_pkg::MUTE_FIRST: begin
            if (tick)
               win_next = safety_pkg::sat_inc(win_reg);
            if (none)
               state_next = safety_pkg::MUTE_IDLE;
            else if (both && win_reg < 24'(safety_pkg::SIMUL_WINDOW_TKS))
               state_next = safety_pkg::MUTE_ACTIVE; // RULE14
            else if (win_reg >= 24'(safety_pkg::SIMUL_WINDOW_TKS))
               state_next = safety_pkg::MUTE_FAULT; // RULE14
         end
         safety_pkg::MUTE_ACTIVE: begin
            if (tick)
               dur_next = safety_pkg::sat_inc(dur_reg);
            if (!both && tick)
               drop_next = safety_pkg::sat_inc(drop_reg);
            else if (both)
               drop_next = '0; // RULE15
            if (dur_reg >= 24'(TIMEOUT_TKS))
               state_next = safety_pkg::MUTE_FAULT; // RULE11 RULE12
            else if (none && drop_reg >= 24'(DROP_TWO_MS))
               state_next = safety_pkg::MUTE_IDLE; // RULE17 RULE16
            else if (one && drop_reg >= 24'(DROP_ONE_MS))
               state_next = safety_pkg::MUTE_FAULT; // RULE15 RULE16
         end
         safety_pkg::MUTE_FAULT: begin
            // Only the restart button leaves here, and only once sensors are free
            if (mif.override && none)
               state_next = safety_pkg::MUTE_IDLE; // RULE13
         end
         default: state_next = safety_pkg::MUTE_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= safety_pkg::MUTE_IDLE;
         win_reg   <= '0;
         dur_reg   <= '0;
         drop_reg  <= '0;
      end else begin
         state_reg <= state_next;
         win_reg   <= win_next;
         dur_reg   <= dur_next;
         drop_reg  <= drop_next;
      end
   end

   assign mif.active = (state_reg == safety_pkg::MUTE_ACTIVE);
   assign mif.fault  = (state_reg == safety_pkg::MUTE_FAULT);
endmodule
`default_nettype wire

// ---- tb/safety_output_ctrl_chk.sv ----
// Checker: port-level assertions on the safety output controller.
// Assumes it is bound into the top module and sees its ports only.
`default_nettype none
module safety_output_ctrl_chk #(
   parameter int unsigned TICK_CYC    = 5,
   parameter int unsigned TIMEOUT_TKS = 100
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic RESTART_INTERLOCK_BTN,
   input wire logic CONTACTOR_FEEDBACK_MONITOR,
   input wire logic FIRST_MUTING_SENSOR,
   input wire logic SECOND_MUTING_SENSOR,
   input wire logic TEST_IN,
   input wire logic SAFETY_SWITCH_OUTPUT,
   input wire logic SIGNAL_OUT,
   input wire logic MUTING_INDICATOR,
   input wire logic RESTART_LOCKED,
   input wire logic FEEDBACK_FAULT
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned btn_age;
   int unsigned both_age;
   int unsigned mm;
   int unsigned mlen;
   // Ages saturate so that a long quiet spell never wraps round
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         btn_age <= 100;
         both_age <= 100;
         mm <= 0;
         mlen <= 0;
      end else begin
         btn_age <= RESTART_INTERLOCK_BTN ? 0 : (btn_age < 100 ? btn_age + 1 : btn_age);
         both_age <= (FIRST_MUTING_SENSOR && SECOND_MUTING_SENSOR) ? 0 :
                     (both_age < 100 ? both_age + 1 : both_age);
         mm <= (CONTACTOR_FEEDBACK_MONITOR != SAFETY_SWITCH_OUTPUT) ? mm + 1 : 0;
         mlen <= MUTING_INDICATOR ? mlen + 1 : 0;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!NRST);
   sequence s_off_hold;
      !SAFETY_SWITCH_OUTPUT [*4];
   endsequence
   sig_inverse_a: assert property (SIGNAL_OUT == !SAFETY_SWITCH_OUTPUT)
      else $error("signal output not inverse of switch output");
   lock_off_a: assert property (RESTART_LOCKED |-> !SAFETY_SWITCH_OUTPUT)
      else $error("output on while restart locked");
   manual_on_a: assert property ($rose(SAFETY_SWITCH_OUTPUT) |-> btn_age < 8)
      else $error("output switched on without button release");
   fb_trip_a: assert property ($rose(FEEDBACK_FAULT) |=> s_off_hold)
      else $error("output not held off after feedback fault");
   fb_window_a: assert property ($rose(FEEDBACK_FAULT) |-> mm >= 499 * TICK_CYC)
      else $error("feedback fault before grace time");
   mute_both_a: assert property ($rose(MUTING_INDICATOR) |-> both_age < 8)
      else $error("muting started without both sensors");
   mute_limit_a: assert property (MUTING_INDICATOR |-> mlen <= (TIMEOUT_TKS + 2) * TICK_CYC)
      else $error("muting outlasted its timeout");
   mute_on_a: assert property (MUTING_INDICATOR && SAFETY_SWITCH_OUTPUT ##1 MUTING_INDICATOR
      && !FEEDBACK_FAULT && !TEST_IN && !$past(TEST_IN, 3) |-> SAFETY_SWITCH_OUTPUT)
      else $error("output dropped during muting");
   test_off_a: assert property ($rose(TEST_IN) |-> ##[1:4] !SAFETY_SWITCH_OUTPUT)
      else $error("output not off during test pulse");
endmodule
bind safety_output_ctrl safety_output_ctrl_chk #(.TICK_CYC(TICK_CYC),
   .TIMEOUT_TKS(TIMEOUT_TKS)) u_chk (.CLK(CLK), .NRST(NRST),
   .RESTART_INTERLOCK_BTN(RESTART_INTERLOCK_BTN),
   .CONTACTOR_FEEDBACK_MONITOR(CONTACTOR_FEEDBACK_MONITOR),
   .FIRST_MUTING_SENSOR(FIRST_MUTING_SENSOR), .SECOND_MUTING_SENSOR(SECOND_MUTING_SENSOR),
   .TEST_IN(TEST_IN), .SAFETY_SWITCH_OUTPUT(SAFETY_SWITCH_OUTPUT), .SIGNAL_OUT(SIGNAL_OUT),
   .MUTING_INDICATOR(MUTING_INDICATOR), .RESTART_LOCKED(RESTART_LOCKED),
   .FEEDBACK_FAULT(FEEDBACK_FAULT));
`default_nettype wire

// ---- tb/contactor_model.sv ----
// Contactor model: feedback contact opens some cycles after outputs switch on.
// Assumes out is a registered level; slow picks a long drop-out delay.
`default_nettype none
module contactor_model (
   input  wire logic clk,
   input  wire logic out,
   input  wire logic stuck,
   input  wire logic slow,
   output logic      fb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_reg = 1'b0;
   logic fb_reg = 1'b0;
   int   cnt = 0;
   always @(posedge clk) begin
      if (out !== last_reg) begin
         last_reg <= out;
         cnt <= 0;
      end else if (cnt < (slow ? 200 : 2)) begin
         cnt <= cnt + 1;
      end else begin
         fb_reg <= out;
      end
   end
   // A welded contact never opens, so feedback stays at 0 V
   assign fb = stuck ? 1'b0 : fb_reg;
endmodule
`default_nettype wire

// ---- tb/tb_safety_output_ctrl.sv ----
// Testbench: restart, scan filter, muting and feedback scenarios.
// Assumes a shortened tick (5 cycles) and a 200 tick muting timeout.
`default_nettype none
module tb_safety_output_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 5;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic beam = 1'b0;
   logic scan = 1'b0;
   logic btn = 1'b0;
   logic s1 = 1'b0;
   logic s2 = 1'b0;
   logic stuck = 1'b0;
   logic slow = 1'b0;
   logic test = 1'b0;
   logic fb, out, sig, mute, locked, fbf, tfl;
   int   errors = 0;
   int   checked = 0;
   always #10 clk = ~clk;
   safety_output_ctrl #(.TIMEOUT_TKS(200), .TICK_CYC(TC)) u_dut (.CLK(clk), .NRST(nrst),
      .BEAM_CLEAR(beam), .SCAN_DONE(scan), .RESTART_INTERLOCK_BTN(btn),
      .CONTACTOR_FEEDBACK_MONITOR(fb), .FIRST_MUTING_SENSOR(s1), .SECOND_MUTING_SENSOR(s2),
      .TEST_IN(test), .SAFETY_SWITCH_OUTPUT(out), .SIGNAL_OUT(sig), .MUTING_INDICATOR(mute),
      .RESTART_LOCKED(locked), .FEEDBACK_FAULT(fbf), .TEST_FAULT(tfl));
   contactor_model u_ctr (.clk(clk), .out(out), .stuck(stuck), .slow(slow), .fb(fb));
   task automatic end_sim;
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait on output w (0 switch, 1 muting, 2 fault) for level v
   task automatic await(input int w, input logic v, input int n);
      repeat (n) begin
         @(negedge clk);
         if ((w == 0 ? out : w == 1 ? mute : fbf) === v) begin
            chk(v, v);
            return;
         end
      end
      chk(~v, v);
      end_sim();
   endtask
   task automatic scans(input logic c, input int n);
      repeat (n) begin
         beam <= c;
         scan <= 1'b1;
         cyc(4);
         scan <= 1'b0;
         cyc(4);
      end
   endtask
   task automatic restart;
      btn <= 1'b1;
      cyc(5);
      btn <= 1'b0;
      await(0, 1'b1, 20);
      cyc(1);
   endtask
   task automatic t_power_up;
      chk(out, 1'b0);
      chk(sig, 1'b1);
      chk(locked, 1'b1);
      scans(1'b1, 2);
      cyc(20);
      chk(out, 1'b0);
      restart();
      chk(sig, 1'b0);
   endtask
   task automatic t_scan;
      slow <= 1'b1;
      scans(1'b0, 2);
      chk(out, 1'b1);
      scans(1'b0, 1);
      await(0, 1'b0, 10);
      scans(1'b1, 2);
      cyc(20);
      chk(out, 1'b0);
      restart();
      slow <= 1'b0;
   endtask
   task automatic t_mute;
      s1 <= 1'b1;
      cyc(100);
      chk(mute, 1'b0);
      s2 <= 1'b1;
      await(1, 1'b1, 10);
      scans(1'b0, 4);
      chk(out, 1'b1);
      scans(1'b1, 1);
      s1 <= 1'b0;
      cyc(20 * TC);
      chk(mute, 1'b1);
      s1 <= 1'b1;
      cyc(10);
      s1 <= 1'b0;
      s2 <= 1'b0;
      await(1, 1'b0, 60 * TC);
      chk(out, 1'b1);
   endtask
   task automatic t_simul;
      s1 <= 1'b1;
      cyc(4010 * TC);
      s2 <= 1'b1;
      cyc(20);
      chk(mute, 1'b0);
      chk(out, 1'b0);
      s1 <= 1'b0;
      s2 <= 1'b0;
      cyc(5);
      restart();
   endtask
   task automatic t_timeout;
      s1 <= 1'b1;
      s2 <= 1'b1;
      await(1, 1'b1, 10);
      cyc(190 * TC);
      chk(mute, 1'b1);
      await(1, 1'b0, 20 * TC);
      cyc(2);
      chk(out, 1'b0);
      s1 <= 1'b0;
      s2 <= 1'b0;
      cyc(5);
      restart();
   endtask
   task automatic t_feedback;
      stuck <= 1'b1;
      cyc(490 * TC);
      chk(fbf, 1'b0);
      await(2, 1'b1, 20 * TC);
      await(0, 1'b0, 3);
      stuck <= 1'b0;
      cyc(20);
      restart();
      chk(fbf, 1'b0);
   endtask
   task automatic t_test;
      test <= 1'b1;
      cyc(20 * TC);
      chk(out, 1'b0);
      chk(locked, 1'b1);
      test <= 1'b0;
      cyc(5);
      chk(tfl, 1'b0);
      restart();
      // Deliberately over-long pulse: a wiring fault the block must latch
      test <= 1'b1;
      cyc(160 * TC);
      chk(tfl, 1'b1);
      test <= 1'b0;
      cyc(5);
      restart();
      chk(tfl, 1'b0);
   endtask
   initial begin
      cyc(8);
      nrst <= 1'b1;
      cyc(2);
      t_power_up();
      t_scan();
      t_mute();
      t_simul();
      t_timeout();
      t_feedback();
      t_test();
      end_sim();
   end
endmodule
`default_nettype wire
